/* File: include/oprc_params.svh */
// Constants for the output parameter record checker
`ifndef OPRC_PARAMS_SVH
`define OPRC_PARAMS_SVH

// Record number that carries the output parameters
`define REC_NUM_PARAM   16'h0080
// Header bytes ahead of the channel fields
`define HDR_LEN         2
// Bytes per channel field
`define CH_BYTES        2
// Header byte positions and expected version
`define HDR_VER_IDX     0
`define HDR_PLEN_IDX    1
`define HDR_VERSION     8'h01
// Error code layout
`define ERR_PREFIX      16'hDF80
`define ERR_NUM         8'hB0
`define ERR_LEN         8'hB1
`define ERR_SLOT        8'hB2
`define ERR_HDR         8'hE0
`define ERR_CODE        8'hE1
`define ERR_CODE_DET    8'h06
`define ERR_DET_NONE    8'h00
`define STATUS_OK       32'h0000_0000
// Channel word fields: diag enables in low byte, substitute mode in high byte
`define DIAG_LSB        0
`define DIAG_W          4
`define SUBST_LSB       8
`define SUBST_W         2
`define SUBST_INVALID   2'h3
// Active parameters after reset: all functions off, outputs shut down
`define CFG_DEFAULT     16'h0000
// Saturation value of the byte counter
`define CNT_MAX         8'hFF

`endif

/* File: include/oprc_pkg.sv */
// Types shared by the output parameter record checker
`default_nettype none

package oprc_pkg;

  // One-hot receive states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_RECV  = 3'h2,
    ST_CHECK = 3'h4
  } rx_state_t;

endpackage : oprc_pkg
`default_nettype wire

/* File: logic/channel_field_checker.sv */
// Decode and coding check of one two-byte channel parameter field
`timescale 1ns/1ps
`default_nettype none
`include "oprc_params.svh"

module channel_field_checker (
  input  wire logic [15:0]            field_i,     // Channel word, byte x+1 high
  output logic      [`DIAG_W-1:0]     diag_en_o,   // Diagnostic enable bits
  output logic      [`SUBST_W-1:0]    subst_o,     // Substitute value behaviour
  output logic                        coding_ok_o  // Field holds a legal encoding
);

  // A set bit means the function is enabled
  assign diag_en_o   = field_i[`DIAG_LSB +: `DIAG_W];
  assign subst_o     = field_i[`SUBST_LSB +: `SUBST_W];
  // Only the substitute behaviour has an illegal code
  assign coding_ok_o = (field_i[`SUBST_LSB +: `SUBST_W] != `SUBST_INVALID);

endmodule : channel_field_checker
`default_nettype wire

/* File: logic/output_param_record_checker.sv */
// Parameter record receiver, validator and active parameter store
`timescale 1ns/1ps
`default_nettype none
`include "oprc_params.svh"

// Operation
// - Record 128 reconfigures the module at run time
// - Validate every value before acting
// - Adopt record completely or not at all
// - On failure keep old settings, report error
// - Unknown record number gives DF 80 B0
// - Wrong record length gives DF 80 B1
// - Invalid or unreachable slot gives DF 80 B2
// - Bad header version or length gives E0
// - Invalid substitute coding gives DF 80 E1 06
// - Enable bit set to one enables function
// - Channel 0 diagnostics apply module-wide
// - Run-time changes leave other channels alone
// - Header then two bytes per channel
// - Reset restores defaults, controller resends record
module output_param_record_checker #(
  parameter int          NUM_CH    = 8,            // Output channels
  parameter logic [15:0] CFG_RESET = `CFG_DEFAULT  // Channel word after reset
) (
  input  wire logic                   clk_sys_i,     // System clock
  input  wire logic                   rst_n_i,       // Async reset, active low
  input  wire logic                   wr_start_i,    // Record write begins
  input  wire logic [15:0]            rec_num_i,     // Record number, with start
  input  wire logic                   slot_ok_i,     // Slot reachable, with start
  input  wire logic                   byte_valid_i,  // Record byte strobe
  input  wire logic [7:0]             byte_data_i,   // Record byte
  input  wire logic                   byte_last_i,   // Last byte of record
  output logic                        busy_o,        // Write in progress
  output logic                        done_o,        // Write finished, one cycle
  output logic                        error_o,       // Write rejected, with done
  output logic [31:0]                 status_o,      // Error code, zero on success
  output logic [NUM_CH*16-1:0]        ch_cfg_o,      // Active channel words
  output logic [`DIAG_W-1:0]          diag_en_o,     // Module-wide diagnostic enables
  output logic [NUM_CH*`SUBST_W-1:0]  subst_mode_o   // Active substitute behaviour
);

  // Expected total record length and parameter block length
  localparam int          PLEN_INT = `CH_BYTES * NUM_CH;
  localparam int          RLEN_INT = `HDR_LEN + PLEN_INT;
  localparam logic [7:0]  REC_LEN  = 8'(RLEN_INT);
  localparam logic [7:0]  PAR_LEN  = 8'(PLEN_INT);
  localparam int          IDX_W    = $clog2(RLEN_INT);

  // Receive state machine
  oprc_pkg::rx_state_t state_r;     // Current state
  oprc_pkg::rx_state_t state_nxt;   // Next state
  logic [15:0]         rec_num_r;   // Latched record number
  logic [15:0]         rec_num_nxt;
  logic                slot_ok_r;   // Latched slot reachability
  logic                slot_ok_nxt;
  logic [7:0]          cnt_r;       // Bytes received, saturating
  logic [7:0]          cnt_nxt;
  logic [7:0]          stage_r   [RLEN_INT];  // Staging copy of the record
  logic [7:0]          stage_nxt [RLEN_INT];

  // Results and active parameters
  logic                done_r;
  logic                done_nxt;
  logic                error_r;
  logic                error_nxt;
  logic [31:0]         status_r;
  logic [31:0]         status_nxt;
  logic [NUM_CH*16-1:0] cfg_r;      // Active parameters
  logic [NUM_CH*16-1:0] cfg_nxt;

  // Candidate parameters decoded from the staging copy
  logic [NUM_CH*16-1:0] cand_w;     // Staged channel words
  logic [NUM_CH-1:0]    coding_ok;  // Per channel coding check

  // Checks, in reporting priority
  logic num_bad;
  logic len_bad;
  logic slot_bad;
  logic hdr_bad;
  logic code_bad;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      // Channel g sits at bytes HDR_LEN + 2g and HDR_LEN + 2g + 1
      assign cand_w[g*16 +: 16] = {stage_r[`HDR_LEN + `CH_BYTES*g + 1],
                                   stage_r[`HDR_LEN + `CH_BYTES*g]};
      channel_field_checker u_chk (
        .field_i     (cand_w[g*16 +: 16]),
        .diag_en_o   (),
        .subst_o     (),
        .coding_ok_o (coding_ok[g])
      );
      assign subst_mode_o[g*`SUBST_W +: `SUBST_W] = cfg_r[g*16 + `SUBST_LSB +: `SUBST_W];
    end
  endgenerate

  // channel 0 diagnostics steer the whole module
  assign diag_en_o = cfg_r[`DIAG_LSB +: `DIAG_W];

  // only the parameter record is known
  assign num_bad  = (rec_num_r != `REC_NUM_PARAM);
  assign len_bad  = (cnt_r != REC_LEN);
  assign slot_bad = !slot_ok_r;
  // header version and parameter block length
  assign hdr_bad  = (stage_r[`HDR_VER_IDX] != `HDR_VERSION) ||
                    (stage_r[`HDR_PLEN_IDX] != PAR_LEN);
  assign code_bad = !(&coding_ok);

  // Next state, latch and staging logic
  always_comb begin
    state_nxt   = state_r;
    rec_num_nxt = rec_num_r;
    slot_ok_nxt = slot_ok_r;
    cnt_nxt     = cnt_r;
    stage_nxt   = stage_r;
    case (state_r)
      oprc_pkg::ST_IDLE: begin
        // Starts are only taken while idle
        if (wr_start_i) begin
          rec_num_nxt = rec_num_i;
          slot_ok_nxt = slot_ok_i;
          cnt_nxt     = 8'h00;
          state_nxt   = oprc_pkg::ST_RECV;
        end
      end
      oprc_pkg::ST_RECV: begin
        if (byte_valid_i) begin
          // Extra bytes beyond the record are counted but not stored
          if (cnt_r < REC_LEN) begin
            stage_nxt[cnt_r[IDX_W-1:0]] = byte_data_i;
          end
          if (cnt_r != `CNT_MAX) begin
            cnt_nxt = cnt_r + 8'h01;
          end
          // nothing acts before the whole record is in
          if (byte_last_i) begin
            state_nxt = oprc_pkg::ST_CHECK;
          end
        end
      end
      oprc_pkg::ST_CHECK: begin
        state_nxt = oprc_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = oprc_pkg::ST_IDLE;
      end
    endcase
  end

  // State, latch and counter registers; staging has its own block below, without reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r   <= oprc_pkg::ST_IDLE;
      rec_num_r <= 16'h0000;
      slot_ok_r <= 1'b0;
      cnt_r     <= 8'h00;
    end else begin
      state_r   <= state_nxt;
      rec_num_r <= rec_num_nxt;
      slot_ok_r <= slot_ok_nxt;
      cnt_r     <= cnt_nxt;
    end
  end

  // Staging memory holds no control state, so it runs without reset
  always_ff @(posedge clk_sys_i) begin
    stage_r <= stage_nxt;
  end

  // Verdict and commit logic
  always_comb begin
    done_nxt   = 1'b0;
    error_nxt  = error_r;
    status_nxt = status_r;
    cfg_nxt    = cfg_r;
    if (state_r == oprc_pkg::ST_CHECK) begin
      done_nxt  = 1'b1;
      error_nxt = 1'b1;
      // first failing check alone is reported
      if (num_bad) begin
        status_nxt = {`ERR_PREFIX, `ERR_NUM, `ERR_DET_NONE};
      end else if (len_bad) begin
        status_nxt = {`ERR_PREFIX, `ERR_LEN, `ERR_DET_NONE};
      end else if (slot_bad) begin
        status_nxt = {`ERR_PREFIX, `ERR_SLOT, `ERR_DET_NONE};
      end else if (hdr_bad) begin
        status_nxt = {`ERR_PREFIX, `ERR_HDR, `ERR_DET_NONE};
      end else if (code_bad) begin
        status_nxt = {`ERR_PREFIX, `ERR_CODE, `ERR_CODE_DET};
      end else begin
        error_nxt  = 1'b0;
        status_nxt = `STATUS_OK;
        cfg_nxt    = cand_w;
      end
      // failed writes leave cfg_nxt at the old settings
    end
  end

  // reset drops run-time changes back to defaults
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_r   <= 1'b0;
      error_r  <= 1'b0;
      status_r <= `STATUS_OK;
      cfg_r    <= {NUM_CH{CFG_RESET}};
    end else begin
      done_r   <= done_nxt;
      error_r  <= error_nxt;
      status_r <= status_nxt;
      cfg_r    <= cfg_nxt;
    end
  end

  // Outputs
  assign busy_o   = (state_r != oprc_pkg::ST_IDLE);
  assign done_o   = done_r;
  assign error_o  = error_r;
  assign status_o = status_r;
  assign ch_cfg_o = cfg_r;

  // Checks on the outcome of each write
  property p_keep_on_error;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (done_o && error_o) |-> $stable(ch_cfg_o);
  endproperty
  a_keep_on_error: assert property (p_keep_on_error)
    else $error("Parameters changed on a rejected write");

  property p_num_code;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (done_o && rec_num_r != `REC_NUM_PARAM) |-> (status_o[31:8] == {`ERR_PREFIX, `ERR_NUM});
  endproperty
  a_num_code: assert property (p_num_code)
    else $error("Unknown record number not reported");

  property p_len_code;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (done_o && rec_num_r == `REC_NUM_PARAM && cnt_r != REC_LEN)
        |-> (status_o[31:8] == {`ERR_PREFIX, `ERR_LEN});
  endproperty
  a_len_code: assert property (p_len_code)
    else $error("Wrong record length not reported");

  property p_slot_code;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (done_o && !num_bad && !len_bad && !slot_ok_r)
        |-> (status_o[31:8] == {`ERR_PREFIX, `ERR_SLOT}) && error_o;
  endproperty
  a_slot_code: assert property (p_slot_code)
    else $error("Bad slot not reported");

  property p_code_err;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (done_o && status_o[15:8] == `ERR_CODE) |-> (status_o[7:0] == `ERR_CODE_DET);
  endproperty
  a_code_err: assert property (p_code_err)
    else $error("Coding error detail byte wrong");

  property p_ok_clean;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (done_o && !error_o) |-> (status_o == `STATUS_OK) && (ch_cfg_o == cand_w);
  endproperty
  a_ok_clean: assert property (p_ok_clean)
    else $error("Accepted write reports error or not adopted");

  property p_done_timing;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state_r == oprc_pkg::ST_RECV && byte_valid_i && byte_last_i) |-> ##2 done_o;
  endproperty
  a_done_timing: assert property (p_done_timing)
    else $error("Verdict not given two cycles after last byte");

  property p_cfg_only_at_done;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (rst_n_i && !$stable(ch_cfg_o)) |-> (done_o && !error_o);
  endproperty
  a_cfg_only_at_done: assert property (p_cfg_only_at_done)
    else $error("Parameters changed outside an accepted write");

  property p_diag_module;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (done_o && !error_o) |-> (diag_en_o == cand_w[`DIAG_LSB +: `DIAG_W]);
  endproperty
  a_diag_module: assert property (p_diag_module)
    else $error("Module diagnostics not taken from channel 0");
endmodule : output_param_record_checker
`default_nettype wire

/* File: test/record_writer_model.sv */
// Controller model that writes parameter records byte by byte
`timescale 1ns/1ps
`default_nettype none

module record_writer_model (
  input  wire logic        clk_sys_i,     // System clock
  output logic             wr_start_o,    // Write begins, one cycle
  output logic [15:0]      rec_num_o,     // Record number, with start
  output logic             slot_ok_o,     // Slot reachable, with start
  output logic             byte_valid_o,  // Byte strobe
  output logic [7:0]       byte_data_o,   // Record byte
  output logic             byte_last_o    // Last byte flag
);
  logic [7:0] rec_bytes [0:19];  // Record image loaded by the bench

  // Idle until the first record
  initial begin
    wr_start_o = 1'b0;
    rec_num_o = 16'h0000;
    slot_ok_o = 1'b0;
    byte_valid_o = 1'b0;
    byte_data_o = 8'h00;
    byte_last_o = 1'b0;
  end

  // sends record
  // Bytes past the image are filler; gap stalls the strobe like a slow master
  task automatic send(input logic [15:0] num, input logic ok, input int len, input int gap);
    @(posedge clk_sys_i);
    wr_start_o <= 1'b1;
    rec_num_o <= num;
    slot_ok_o <= ok;
    @(posedge clk_sys_i);
    wr_start_o <= 1'b0;
    // Released qualifiers must not keep their old value
    rec_num_o <= ~num;
    slot_ok_o <= ~ok;
    for (int i = 0; i < len; i++) begin
      byte_valid_o <= 1'b1;
      byte_data_o <= (i < 20) ? rec_bytes[i] : 8'h5A;
      byte_last_o <= (i == len - 1);
      @(posedge clk_sys_i);
      // Released data line toggles so nothing stale looks valid
      if (gap > 0 || i == len - 1) begin
        byte_valid_o <= 1'b0;
        byte_last_o <= 1'b0;
        byte_data_o <= ~byte_data_o;
        // No stall after the last byte, so the verdict is not missed
        if (i != len - 1) repeat (gap) @(posedge clk_sys_i);
      end
    end
  endtask : send
endmodule : record_writer_model
`default_nettype wire

/* File: test/output_param_record_checker_tb_top.sv */
// Self-checking bench for the parameter record checker
`timescale 1ns/1ps
`default_nettype none

module output_param_record_checker_tb_top;
  typedef struct {
    logic [15:0] num;   // Record number
    logic        ok;    // Slot reachable
    int          len;   // Bytes sent
    logic [7:0]  ver;   // Header version byte
    logic [7:0]  plen;  // Header length byte
    int          sel;   // Channel that gets the new word
    logic [15:0] word;  // New channel word
    int          gap;   // Idle cycles between bytes
    logic [31:0] st;    // Expected status code
  } row_t;

  logic          clk_sys_i;   // System clock
  logic          rst_n_i;     // Reset, active low
  logic          wr_start, slot_ok, b_valid, b_last;
  logic [15:0]   rec_num;
  logic [7:0]    b_data;
  logic          busy_o, done_o, error_o;
  logic [31:0]   status_o;
  logic [127:0]  ch_cfg_o;
  logic [3:0]    diag_en_o;
  logic [15:0]   subst_mode_o;
  logic [15:0]   exp_cfg [0:7];  // Expected active words
  int            failures, n_tests;
  row_t          rows [0:14];

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  output_param_record_checker output_param_record_checker_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wr_start_i(wr_start), .rec_num_i(rec_num),
    .slot_ok_i(slot_ok), .byte_valid_i(b_valid), .byte_data_i(b_data), .byte_last_i(b_last),
    .busy_o(busy_o), .done_o(done_o), .error_o(error_o), .status_o(status_o),
    .ch_cfg_o(ch_cfg_o), .diag_en_o(diag_en_o), .subst_mode_o(subst_mode_o));

  record_writer_model record_writer_model_inst (
    .clk_sys_i(clk_sys_i), .wr_start_o(wr_start), .rec_num_o(rec_num), .slot_ok_o(slot_ok),
    .byte_valid_o(b_valid), .byte_data_o(b_data), .byte_last_o(b_last));

  task automatic chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Compares every parameter output against the shadow words
  task automatic chk_cfg();
    logic [127:0] w;
    logic [15:0]  s;
    for (int g = 0; g < 8; g++) begin
      w[16*g +: 16] = exp_cfg[g];
      s[2*g +: 2] = exp_cfg[g][9:8];
    end
    chk("ch_cfg", ch_cfg_o, w);
    chk("diag", diag_en_o, exp_cfg[0][3:0]);
    chk("subst", subst_mode_o, s);
  endtask : chk_cfg

  task automatic stop_test();
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // Sends one row, waits for the verdict under a bound, checks it
  task automatic run_row(input row_t r);
    int k;
    record_writer_model_inst.rec_bytes[0] = r.ver;
    record_writer_model_inst.rec_bytes[1] = r.plen;
    for (int g = 0; g < 8; g++) begin
      record_writer_model_inst.rec_bytes[2+2*g] = (g == r.sel) ? r.word[7:0] : exp_cfg[g][7:0];
      record_writer_model_inst.rec_bytes[3+2*g] = (g == r.sel) ? r.word[15:8] : exp_cfg[g][15:8];
    end
    for (int i = 18; i < 20; i++) record_writer_model_inst.rec_bytes[i] = 8'hA5;
    record_writer_model_inst.send(r.num, r.ok, r.len, r.gap);
    k = 0;
    while (done_o !== 1'b1 && k < 40) begin
      @(negedge clk_sys_i);
      k++;
    end
    chk("done", done_o, 1'b1);
    chk("busy", busy_o, 1'b0);
    chk("status", status_o, r.st);
    chk("error", error_o, r.st !== 32'h0000_0000);
    // Only a clean record replaces the active words
    if (r.st === 32'h0000_0000) exp_cfg[r.sel] = r.word;
    chk_cfg();
    @(negedge clk_sys_i);
    chk("done_pulse", done_o, 1'b0);
  endtask : run_row

  // Watchdog far above the expected run of about seven hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    stop_test();
  end

  initial begin
    failures = 0;
    n_tests = 0;
    rst_n_i = 1'b0;
    for (int g = 0; g < 8; g++) exp_cfg[g] = 16'h0000;
    // Clean rows, each error alone, a 274-byte length that saturates the count, then mixed errors for priority
    rows = '{
      '{16'h0080, 1, 18, 8'h01, 8'h10, 0, 16'h020F, 0, 32'h0000_0000},
      '{16'h0080, 1, 18, 8'h01, 8'h10, 5, 16'h01A5, 2, 32'h0000_0000},
      '{16'h0081, 1, 18, 8'h01, 8'h10, 2, 16'h0001, 0, 32'hDF80_B000},
      '{16'h0080, 1, 17, 8'h01, 8'h10, 2, 16'h0001, 0, 32'hDF80_B100},
      '{16'h0080, 1, 19, 8'h01, 8'h10, 2, 16'h0001, 0, 32'hDF80_B100},
      '{16'h0080, 1, 274, 8'h01, 8'h10, 2, 16'h0001, 0, 32'hDF80_B100},
      '{16'h0080, 0, 18, 8'h01, 8'h10, 2, 16'h0001, 1, 32'hDF80_B200},
      '{16'h0080, 1, 18, 8'h02, 8'h10, 2, 16'h0001, 0, 32'hDF80_E000},
      '{16'h0080, 1, 18, 8'h01, 8'h0F, 2, 16'h0001, 0, 32'hDF80_E000},
      '{16'h0080, 1, 18, 8'h01, 8'h10, 7, 16'h0300, 0, 32'hDF80_E106},
      '{16'h0000, 0, 17, 8'h00, 8'h10, 2, 16'h0001, 0, 32'hDF80_B000},
      '{16'h0080, 0, 19, 8'h01, 8'h10, 2, 16'h0001, 0, 32'hDF80_B100},
      '{16'h0080, 0, 18, 8'h00, 8'h10, 2, 16'h0001, 0, 32'hDF80_B200},
      '{16'h0080, 1, 18, 8'h02, 8'h10, 3, 16'h0300, 0, 32'hDF80_E000},
      '{16'h0080, 1, 18, 8'h01, 8'h10, 7, 16'h0203, 0, 32'h0000_0000}};
    repeat (16) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk_cfg();
    chk("status_rst", status_o, 32'h0000_0000);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int r = 0; r < 15; r++) run_row(rows[r]);
    // Restart mid-run drops run-time words
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    for (int g = 0; g < 8; g++) exp_cfg[g] = 16'h0000;
    @(negedge clk_sys_i);
    chk_cfg();
    @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    run_row(rows[0]);
    stop_test();
  end
endmodule : output_param_record_checker_tb_top
`default_nettype wire
